// ### design/tpsp_defines.svh
// Constants of the two-wire pointer slave port
`ifndef TPSP_DEFINES_SVH
`define TPSP_DEFINES_SVH
// ****************************************
// Timing
// ****************************************
`define TPSP_CLK_HZ     10000000
`define TPSP_TMO_MS     32
`define TPSP_TMO_CYCLES ((`TPSP_TMO_MS * `TPSP_CLK_HZ) / 1000)
`define TPSP_TMO_W      19
`define TPSP_FILT_FS    2'h2
`define TPSP_FILT_HS    2'h0
// ****************************************
// Addresses and codes
// ****************************************
`define TPSP_ADDR_BASE  7'h4C
`define TPSP_ADDR_0Z    7'h48
`define TPSP_ADDR_Z0    7'h49
`define TPSP_ADDR_1Z    7'h4A
`define TPSP_ADDR_Z1    7'h4B
`define TPSP_ADDR_ZZ    7'h37
`define TPSP_HS_CODE    5'h01
`define TPSP_BIT_LAST   4'h8
// ****************************************
// Write buffer
// ****************************************
`define TPSP_FIFO_W     16
`define TPSP_FIFO_D     16
`endif

// ### design/tpsp_pkg.sv
// Types shared by the two-wire pointer slave port
`include "tpsp_defines.svh"
package tpsp_pkg;
    typedef enum logic [7:0] {
        ST_IDLE     = 8'h01,
        ST_ADDR     = 8'h02,
        ST_ADDR_ACK = 8'h04,
        ST_RX       = 8'h08,
        ST_RX_ACK   = 8'h10,
        ST_TX       = 8'h20,
        ST_TX_ACK   = 8'h40,
        ST_IGNORE   = 8'h80
    } tpsp_phase_t;
    typedef struct packed {
        logic [7:0] index;
        logic [7:0] data;
    } tpsp_wr_t;
    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       filt;
        logic [1:0] cnt;
    } tpsp_sync_t;
    typedef struct packed {
        tpsp_phase_t             st;
        logic                    scl_d;
        logic                    sda_d;
        logic [3:0]              cnt;
        logic [7:0]              sh;
        logic                    rw;
        logic                    first;
        logic                    tx_lo;
        logic [7:0]              index;
        logic                    sda_oe;
        logic                    sda_out;
        logic                    hs;
        logic                    in_frame;
        logic [`TPSP_TMO_W-1:0]  tmo;
        logic [3:0]              strap_s1;
        logic [3:0]              strap_s2;
        logic [1:0]              strap_age;
        logic                    strap_ok;
        logic [6:0]              own;
        logic                    push;
        tpsp_wr_t                push_data;
        logic                    wr_valid;
        tpsp_wr_t                wr;
    } tpsp_state_t;
endpackage : tpsp_pkg

// ### design/tpsp_sync.sv
// Two-flop synchroniser with a spike filter for one bus line
`timescale 1ns/1ps
`default_nettype none
`include "tpsp_defines.svh"
module tpsp_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Line
    input  wire logic raw,
    input  wire logic hs,
    output logic      filt
);
    tpsp_pkg::tpsp_sync_t q;
    tpsp_pkg::tpsp_sync_t next_q;
    logic [1:0]           lim;

    assign lim  = hs ? `TPSP_FILT_HS : `TPSP_FILT_FS;
    assign filt = q.filt;

    // A change must persist for lim+1 samples before it is seen
    always_comb begin
        next_q    = q;
        next_q.s1 = raw;
        next_q.s2 = q.s1;
        if (q.s2 == q.filt) begin
            next_q.cnt = 2'h0;
        end else if (q.cnt >= lim) begin
            next_q.filt = q.s2;
            next_q.cnt  = 2'h0;
        end else begin
            next_q.cnt = q.cnt + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= 5'h1C;
        end else begin
            q <= next_q;
        end
    end
endmodule : tpsp_sync
`default_nettype wire

// ### design/tpsp_fifo.sv
// Write-data FIFO between the bus engine and the register bank
`timescale 1ns/1ps
`default_nettype none
module tpsp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } tpsp_fptr_t;
    tpsp_fptr_t       q;
    tpsp_fptr_t       next_q;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             full;
    logic             empty;

    assign empty     = q.wp == q.rp;
    assign full      = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[q.rp[AW-1:0]];

    always_comb begin
        next_q = q;
        if (in_valid && !full) begin
            next_q.wp = q.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            next_q.rp = q.rp + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem[q.wp[AW-1:0]] <= in_data;
        end
    end
endmodule : tpsp_fifo
`default_nettype wire

// ### design/tpsp_port.sv
// Two-wire pointer slave port: bus engine, strap address, write path
`timescale 1ns/1ps
`default_nettype none
`include "tpsp_defines.svh"
// Functional notes
// RULE1: First data byte after a write address becomes the register index.
// RULE2: Controller sends an index byte first in every write; later bytes are data.
// RULE3: Reads return the register chosen by the last written index.
// RULE4: An index-only write followed by a START and read address is accepted.
// RULE5: Reads never alter the index; only a later write changes it.
// RULE6: Two-byte registers go out high byte first, then low byte.
// RULE7: Both lines high means idle; the port releases SDA while idle.
// RULE8: SDA falling with SCL high is START and begins address reception.
// RULE9: SDA rising with SCL high is STOP; STOP or repeated START ends transfer.
// RULE10: Any number of data bytes per transfer, until the controller ends it; with the write buffer full a byte is not acknowledged and the rest ignored.
// RULE11: The addressed receiver holds SDA low through the acknowledge clock high.
// RULE12: Controller not-acknowledge on a read makes the port release SDA.
// RULE13: Master code after START is not acknowledged but selects high-speed filters.
// RULE14: High-speed filtering lasts until STOP, then fast-mode returns.
// RULE15: SCL or SDA low for 32 ms inside a frame resets the engine.
// RULE16: After timeout release SDA and ignore the bus until a new START.
// RULE17: Own address comes from two three-state straps, nine choices.
// RULE18: Address byte is seven bits plus direction; ack on ninth pulse; MSB first.
// RULE19: Lines synchronised; conditions and edges from samples; foreign addresses ignored.
// RULE20: Index, write strobe with data, and read data face the register bank.
module tpsp_port #(
    parameter int TMO_CYCLES = `TPSP_TMO_CYCLES
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // Bus lines, SDA open drain
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE,
    output logic             HS_MODE,
    // Address straps: bit 1 floating, bit 0 level
    input  wire logic [1:0]  ADDR_STRAP_LOW,
    input  wire logic [1:0]  ADDR_STRAP_HIGH,
    // Register bank
    output logic [7:0]       REG_INDEX,
    output logic             WR_VALID,
    output logic [7:0]       WR_INDEX,
    output logic [7:0]       WR_DATA,
    input  wire logic        WR_READY,
    input  wire logic [15:0] RD_DATA,
    input  wire logic        RD_TWO_BYTE
);
    tpsp_pkg::tpsp_state_t q;
    tpsp_pkg::tpsp_state_t next_q;
    tpsp_pkg::tpsp_wr_t    fifo_data;
    logic                  fifo_ready;
    logic                  fifo_valid;
    logic                  pop;
    logic                  scl;
    logic                  sda;
    logic                  rise;
    logic                  fall;
    logic                  start;
    logic                  stop;
    logic                  byte_end;
    logic                  own_hit;
    logic                  hs_code;
    logic                  load;
    logic                  tmo_hit;
    logic [7:0]            tx_byte;
    logic                  rd_msb;

    // ****************************************
    // Strap decode
    // ****************************************
    function automatic logic [6:0] addr_sel(input logic [1:0] lo, input logic [1:0] hi);
        if (lo[1] && hi[1]) begin
            addr_sel = `TPSP_ADDR_ZZ;
        end else if (hi[1]) begin
            addr_sel = lo[0] ? `TPSP_ADDR_1Z : `TPSP_ADDR_0Z;
        end else if (lo[1]) begin
            addr_sel = hi[0] ? `TPSP_ADDR_Z1 : `TPSP_ADDR_Z0;
        end else begin
            addr_sel = `TPSP_ADDR_BASE | {5'h00, lo[0], hi[0]};
        end
    endfunction : addr_sel

    // ****************************************
    // Line synchronisers
    // ****************************************
    logic [1:0] raw_lines;
    logic [1:0] filt_lines;
    assign raw_lines = {SCL_IN, SDA_IN};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_line
            tpsp_sync u_sync (
                .clk   (CLK),
                .reset (RESET),
                .raw   (raw_lines[gi]),
                .hs    (q.hs),
                .filt  (filt_lines[gi])
            );
        end
    endgenerate

    assign scl = filt_lines[1];
    assign sda = filt_lines[0];

    // ****************************************
    // Bus events
    // ****************************************
    assign rise     = scl && !q.scl_d;
    assign fall     = !scl && q.scl_d;
    assign start    = scl && q.scl_d && q.sda_d && !sda; // see RULE8 see RULE19
    assign stop     = scl && q.scl_d && !q.sda_d && sda; // see RULE9 see RULE19
    assign byte_end = fall && (q.cnt == `TPSP_BIT_LAST);
    assign own_hit  = q.strap_ok && (q.sh[7:1] == q.own); // see RULE17 see RULE19
    assign hs_code  = q.sh[7:3] == `TPSP_HS_CODE;
    assign load     = fall && (((q.st == tpsp_pkg::ST_ADDR_ACK) && q.rw)
                               || (q.st == tpsp_pkg::ST_TX_ACK));
    // Two-byte registers alternate high then low byte
    assign tx_byte  = (RD_TWO_BYTE && !q.tx_lo) ? RD_DATA[15:8] : RD_DATA[7:0]; // see RULE6
    assign tmo_hit  = q.in_frame && !(scl && sda)
                      && (q.tmo == `TPSP_TMO_W'(TMO_CYCLES - 1)); // see RULE15
    assign pop      = fifo_valid && (!q.wr_valid || WR_READY);
    assign rd_msb   = RD_DATA[15];

    // ****************************************
    // Write buffer
    // ****************************************
    tpsp_fifo #(
        .WIDTH (`TPSP_FIFO_W),
        .DEPTH (`TPSP_FIFO_D)
    ) u_fifo (
        .clk       (CLK),
        .reset     (RESET),
        .in_valid  (q.push),
        .in_ready  (fifo_ready),
        .in_data   (q.push_data),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_q          = q;
        next_q.scl_d    = scl;
        next_q.sda_d    = sda;
        next_q.push     = 1'b0;
        next_q.strap_s1 = {ADDR_STRAP_HIGH, ADDR_STRAP_LOW};
        next_q.strap_s2 = q.strap_s1;
        // Straps are caught once, after the synchroniser has settled
        if (!q.strap_ok) begin
            if (q.strap_age == 2'h3) begin
                next_q.own      = addr_sel(q.strap_s2[1:0], q.strap_s2[3:2]); // see RULE17
                next_q.strap_ok = 1'b1;
            end else begin
                next_q.strap_age = q.strap_age + 2'h1;
            end
        end
        if (!q.in_frame || (scl && sda)) begin
            next_q.tmo = '0;
        end else begin
            next_q.tmo = q.tmo + 1'b1;
        end
        case (q.st)
            tpsp_pkg::ST_ADDR: begin
                if (rise) begin
                    next_q.sh  = {q.sh[6:0], sda}; // see RULE18
                    next_q.cnt = q.cnt + 4'h1;
                end else if (byte_end) begin
                    next_q.cnt = 4'h0;
                    if (hs_code) begin
                        next_q.hs = 1'b1; // see RULE13
                        next_q.st = tpsp_pkg::ST_IGNORE;
                    end else if (own_hit) begin
                        next_q.rw     = q.sh[0];
                        next_q.tx_lo  = 1'b0;
                        next_q.sda_oe = 1'b1; // see RULE18 see RULE11
                        next_q.st     = tpsp_pkg::ST_ADDR_ACK;
                    end else begin
                        next_q.st = tpsp_pkg::ST_IGNORE; // see RULE19
                    end
                end
            end
            tpsp_pkg::ST_ADDR_ACK: begin
                if (fall && !q.rw) begin
                    next_q.sda_oe = 1'b0;
                    next_q.first  = 1'b1; // see RULE2
                    next_q.st     = tpsp_pkg::ST_RX;
                end
            end
            tpsp_pkg::ST_RX: begin
                if (rise) begin
                    next_q.sh  = {q.sh[6:0], sda};
                    next_q.cnt = q.cnt + 4'h1;
                end else if (byte_end) begin
                    next_q.cnt = 4'h0;
                    if (q.first) begin
                        next_q.index  = q.sh; // see RULE1 see RULE4
                        next_q.first  = 1'b0;
                        next_q.sda_oe = 1'b1;
                        next_q.st     = tpsp_pkg::ST_RX_ACK;
                    end else if (fifo_ready) begin
                        next_q.push      = 1'b1; // see RULE20 see RULE10
                        next_q.push_data = {q.index, q.sh};
                        next_q.sda_oe    = 1'b1;
                        next_q.st        = tpsp_pkg::ST_RX_ACK;
                    end else begin
                        // Buffer full: the byte is refused with a not-acknowledge
                        next_q.st = tpsp_pkg::ST_IGNORE;
                    end
                end
            end
            tpsp_pkg::ST_RX_ACK: begin
                if (fall) begin
                    next_q.sda_oe = 1'b0; // see RULE11
                    next_q.st     = tpsp_pkg::ST_RX;
                end
            end
            tpsp_pkg::ST_TX: begin
                if (rise) begin
                    next_q.cnt = q.cnt + 4'h1;
                end else if (fall) begin
                    if (q.cnt == `TPSP_BIT_LAST) begin
                        next_q.sda_oe = 1'b0;
                        next_q.cnt    = 4'h0;
                        next_q.st     = tpsp_pkg::ST_TX_ACK;
                    end else begin
                        next_q.sh     = {q.sh[6:0], 1'b0}; // see RULE18
                        next_q.sda_oe = !q.sh[6];
                    end
                end
            end
            tpsp_pkg::ST_TX_ACK: begin
                if (rise && sda) begin
                    next_q.st = tpsp_pkg::ST_IGNORE; // see RULE12
                end
            end
            tpsp_pkg::ST_IDLE, tpsp_pkg::ST_IGNORE: begin
                next_q.sda_oe = 1'b0; // see RULE7
            end
            default: begin
                next_q.st     = tpsp_pkg::ST_IDLE;
                next_q.sda_oe = 1'b0;
            end
        endcase
        // Read data is sampled as each byte is loaded
        if (load) begin
            next_q.sh     = tx_byte; // see RULE3 see RULE20
            next_q.sda_oe = !tx_byte[7]; // see RULE6
            next_q.tx_lo  = RD_TWO_BYTE ? !q.tx_lo : 1'b0;
            next_q.cnt    = 4'h0;
            next_q.st     = tpsp_pkg::ST_TX;
        end
        if (start) begin
            next_q.st       = tpsp_pkg::ST_ADDR; // see RULE8 see RULE9
            next_q.cnt      = 4'h0;
            next_q.sda_oe   = 1'b0;
            next_q.in_frame = 1'b1;
        end else if (stop) begin
            next_q.st       = tpsp_pkg::ST_IDLE; // see RULE9
            next_q.sda_oe   = 1'b0;
            next_q.hs       = 1'b0; // see RULE14
            next_q.in_frame = 1'b0;
        end
        if (tmo_hit) begin
            next_q.st       = tpsp_pkg::ST_IGNORE; // see RULE16
            next_q.sda_oe   = 1'b0;
            next_q.hs       = 1'b0;
            next_q.in_frame = 1'b0;
            next_q.tmo      = '0;
        end
        // Register bank write strobe, held until taken
        if (pop) begin
            next_q.wr_valid = 1'b1; // see RULE20
            next_q.wr       = fifo_data;
        end else if (WR_READY) begin
            next_q.wr_valid = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            q       <= '0;
            q.st    <= tpsp_pkg::ST_IDLE;
            q.scl_d <= 1'b1;
            q.sda_d <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign SDA_OUT   = q.sda_out;
    assign SDA_OE    = q.sda_oe;
    assign HS_MODE   = q.hs;
    assign REG_INDEX = q.index;
    assign WR_VALID  = q.wr_valid;
    assign WR_INDEX  = q.wr.index;
    assign WR_DATA   = q.wr.data;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    sequence s_start;
        start;
    endsequence
    sequence s_stop;
        stop && !tmo_hit;
    endsequence
    sequence s_addr_end;
        (q.st == tpsp_pkg::ST_ADDR) && byte_end && !tmo_hit;
    endsequence
    sequence s_rx_end;
        (q.st == tpsp_pkg::ST_RX) && byte_end && !tmo_hit;
    endsequence

    property p_start_addr;
        s_start ##0 !tmo_hit |=> (q.st == tpsp_pkg::ST_ADDR) && (q.cnt == 4'h0) && !SDA_OE;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("START missed"); // see RULE8

    property p_stop_release;
        s_stop |=> !SDA_OE && (q.st == tpsp_pkg::ST_IDLE) ##1 !SDA_OE;
    endproperty
    a_stop_release: assert property (p_stop_release) else $error("Held after STOP"); // see RULE9

    property p_idle_release;
        (q.st == tpsp_pkg::ST_IDLE) && !start |=> !SDA_OE;
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("Driven in idle"); // see RULE7

    property p_own_ack;
        s_addr_end ##0 (own_hit && !hs_code) |=> SDA_OE && (q.st == tpsp_pkg::ST_ADDR_ACK);
    endproperty
    a_own_ack: assert property (p_own_ack) else $error("Own address not acked"); // see RULE18

    property p_foreign_ignore;
        s_addr_end ##0 (!own_hit && !hs_code) |=> !SDA_OE && (q.st == tpsp_pkg::ST_IGNORE);
    endproperty
    a_foreign_ignore: assert property (p_foreign_ignore) else $error("Foreign ack"); // see RULE19

    property p_hs_code;
        s_addr_end ##0 hs_code |=> HS_MODE && !SDA_OE;
    endproperty
    a_hs_code: assert property (p_hs_code) else $error("Master code mishandled"); // see RULE13

    property p_hs_stop;
        s_stop |=> !HS_MODE;
    endproperty
    a_hs_stop: assert property (p_hs_stop) else $error("High speed after STOP"); // see RULE14

    property p_index_latch;
        s_rx_end ##0 q.first |=> (REG_INDEX == $past(q.sh)) && SDA_OE;
    endproperty
    a_index_latch: assert property (p_index_latch) else $error("Index not latched"); // see RULE1

    property p_index_hold;
        (q.st != tpsp_pkg::ST_RX) |=> $stable(REG_INDEX);
    endproperty
    a_index_hold: assert property (p_index_hold) else $error("Index changed"); // see RULE5

    property p_push;
        s_rx_end ##0 (!q.first && fifo_ready) |=> q.push && SDA_OE
            && (q.push_data.index == REG_INDEX);
    endproperty
    a_push: assert property (p_push) else $error("Data byte not passed to buffer"); // see RULE10

    property p_ack_hold;
        (q.st == tpsp_pkg::ST_RX_ACK) && !fall && !start && !stop && !tmo_hit |=> SDA_OE;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("Ack dropped early"); // see RULE11

    property p_msb_first;
        (q.st == tpsp_pkg::ST_ADDR_ACK) && fall && q.rw && RD_TWO_BYTE && !tmo_hit
            |=> (SDA_OE == !$past(rd_msb)) && (q.st == tpsp_pkg::ST_TX);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("Low byte sent first"); // see RULE6

    property p_nack_release;
        (q.st == tpsp_pkg::ST_TX_ACK) && rise && sda && !tmo_hit
            |=> !SDA_OE && (q.st == tpsp_pkg::ST_IGNORE);
    endproperty
    a_nack_release: assert property (p_nack_release) else $error("Kept after NACK"); // see RULE12

    property p_timeout;
        tmo_hit |=> (q.st == tpsp_pkg::ST_IGNORE) && !SDA_OE && !q.in_frame;
    endproperty
    a_timeout: assert property (p_timeout) else $error("Timeout not taken"); // see RULE15

    property p_tmo_ignore;
        (q.st == tpsp_pkg::ST_IGNORE) && !start |=> (q.st == tpsp_pkg::ST_IGNORE)
            || (q.st == tpsp_pkg::ST_IDLE);
    endproperty
    a_tmo_ignore: assert property (p_tmo_ignore) else $error("Ignore state left"); // see RULE16
endmodule : tpsp_port
`default_nettype wire

// ### tb/tpsp_ctl_model.sv
// Behavioural two-wire bus controller that makes the serial clock
`timescale 1ns/1ps
`default_nettype none
module tpsp_ctl_model (
    // Bus lines
    output logic      scl,
    output logic      sda,
    input  wire logic line
);
    // SCL stands high outside frames; the low phase covers the port's sync delay
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic bw(input logic b);
        #400 sda = b;
        #800 scl = 1'b1;
        #400 scl = 1'b0;
    endtask : bw
    task automatic br(output logic r);
        #400 sda = 1'b1;
        #800 scl = 1'b1;
        #200 r = line;
        #200 scl = 1'b0;
    endtask : br
    task automatic start;
        #400 sda = 1'b1;
        #400 scl = 1'b1;
        #400 sda = 1'b0;
        #400 scl = 1'b0;
    endtask : start
    task automatic stop;
        #400 sda = 1'b0;
        #400 scl = 1'b1;
        #400 sda = 1'b1;
    endtask : stop
    task automatic wb(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bw(b[i]);
        br(r);
        ack = !r;
    endtask : wb
    task automatic rb(input logic ack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) br(b[i]);
        bw(!ack);
    endtask : rb
endmodule : tpsp_ctl_model
`default_nettype wire

// ### tb/two_wire_pointer_slave_port_bench.sv
// Self-checking bench of the two-wire pointer slave port
`timescale 1ns/1ps
`default_nettype none
module two_wire_pointer_slave_port_bench;
    localparam logic [6:0] ADR = 7'h48;
    logic clk = 1'b0, reset = 1'b1, ready = 1'b1, two = 1'b0, a, oe, hs, wv, scl, sda;
    logic [7:0] idx, wi, wd, b;
    logic [15:0] last;
    int num_errors = 0, checks_done = 0, n_wr = 0, n0;
    logic [16:0] rows [3] = '{{1'b1, 16'h00a5}, {1'b0, 16'hff5a}, {1'b1, 16'h7e00}};
    logic [1:0] s_lo = 2'b00, s_hi = 2'b10;
    logic so;
    // Pin changes land between clock edges, clear of the samplers
    wire #20 scl_dl = scl;
    wire #20 sda_dl = sda;
    wire line = sda_dl & !oe;
    always #50 clk = ~clk;
    tpsp_ctl_model i_ctl (.scl(scl), .sda(sda), .line(line));
    tpsp_port #(.TMO_CYCLES(1000)) i_dut (.CLK(clk), .RESET(reset), .SCL_IN(scl_dl),
        .SDA_IN(line), .SDA_OUT(so), .SDA_OE(oe), .HS_MODE(hs), .ADDR_STRAP_LOW(s_lo),
        .ADDR_STRAP_HIGH(s_hi), .REG_INDEX(idx), .WR_VALID(wv), .WR_INDEX(wi),
        .WR_DATA(wd), .WR_READY(ready), .RD_DATA({~idx, idx}), .RD_TWO_BYTE(two));
    always @(posedge clk) if (wv === 1'b1 && ready === 1'b1) begin
        n_wr <= n_wr + 1;
        last <= {wi, wd};
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] i, input logic t);
        @(posedge clk) two <= t;
        i_ctl.start();
        i_ctl.wb({ADR, 1'b1}, a);
        chk("ack read", 1, a);
        i_ctl.rb(t, b);
        chk("first byte", {t ? ~i : i}, b);
        if (t) i_ctl.rb(1'b0, b);
        if (t) chk("second byte", i, b);
        i_ctl.stop();
    endtask : rd
    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (50000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        chk("idle release", 0, oe);
        repeat (20) @(posedge clk);
        foreach (rows[k]) begin
            n0 = n_wr;
            i_ctl.start();
            i_ctl.wb({ADR, 1'b0}, a);
            i_ctl.wb(rows[k][15:8], b[0]);
            i_ctl.wb(rows[k][7:0], b[1]);
            chk("write acks", 7, {a, b[1:0]});
            i_ctl.stop();
            repeat (10) @(posedge clk);
            chk("index", rows[k][15:8], idx);
            chk("bank write", {rows[k][15:0]}, last);
            chk("write count", n0 + 1, n_wr[15:0]);
            rd(rows[k][15:8], rows[k][16]);
            rd(rows[k][15:8], rows[k][16]);
            $display("row %0d done", k);
        end
        i_ctl.start();
        i_ctl.wb({ADR, 1'b0}, a);
        i_ctl.wb(8'h33, a);
        rd(8'h33, 1'b0);
        i_ctl.start();
        i_ctl.wb({7'h4c, 1'b0}, a);
        chk("foreign nack", 0, a);
        i_ctl.start();
        i_ctl.wb(8'h0b, a);
        chk("code nack", 0, a);
        chk("hs on", 1, hs);
        rd(8'h33, 1'b1);
        repeat (10) @(posedge clk);
        chk("hs off", 0, hs);
        $display("index only, foreign and code done");
        ready <= 1'b0;
        n0 = n_wr;
        i_ctl.start();
        i_ctl.wb({ADR, 1'b0}, a);
        i_ctl.wb(8'h44, a);
        for (int k = 0; k < 17; k++) i_ctl.wb(k[7:0], a);
        chk("last fit ack", 1, a);
        i_ctl.wb(8'h99, a);
        chk("full nack", 0, a);
        i_ctl.stop();
        ready <= 1'b1;
        repeat (80) @(posedge clk);
        chk("drained", 16'(n0 + 17), n_wr[15:0]);
        chk("drain last", 16'h4410, last);
        i_ctl.start();
        for (int k = 7; k >= 0; k--) i_ctl.bw(k == 0 ? 1'b0 : ADR[k - 1]);
        repeat (10) @(posedge clk);
        chk("stuck ack", 2, {oe, so});
        repeat (1200) @(posedge clk);
        chk("timeout release", 0, oe);
        i_ctl.wb({ADR, 1'b0}, a);
        chk("ignored after timeout", 0, a);
        i_ctl.stop();
        $display("fifo and timeout done");
        s_lo <= 2'b10;
        s_hi <= 2'b10;
        reset <= 1'b1;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (20) @(posedge clk);
        chk("index after reset", 0, idx);
        i_ctl.start();
        i_ctl.wb({7'h37, 1'b0}, a);
        chk("strap address ack", 1, a);
        i_ctl.stop();
        $display("strap and reset done");
        give_verdict();
    end
endmodule : two_wire_pointer_slave_port_bench
`default_nettype wire
